/* File: core/clkgen_cfg.svh */
`ifndef CLKGEN_CFG_SVH
`define CLKGEN_CFG_SVH
// Functional notes
// RULE_01 - Reset is synchronous, active low; 0 holds reset, 1 runs.
// RULE_02 - A run starts only on a rising edge of config_trigger.
// RULE_03 - programming_complete is 0 during a run, 1 after all writes.
// RULE_04 - Block is I2C master: drives serial clock, data is bidirectional.
// RULE_05 - Four-channel variant programs each channel from its own select.
// RULE_06 - Select codes: 0 down, 1..7 give 644.53125 down to 100 MHz.
// RULE_07 - Single-select variant: 0000 275, 0001 250, 0010 225 MHz.
// RULE_08 - New selects plus a new start edge reprogram the chip.
// RULE_09 - Register values sit in an editable table in a sequencer module.
// RULE_10 - I2C device address is 0xEE in 8-bit write form.
// RULE_11 - Outside logic holds chip enable low and ties chip reset to system reset.
// RULE_12 - Serial clock at most 400 kHz; start, address, data, stop, ack check.
// ==========================================================
// Bus, table and select constants
`define DEV_ADDR_W 8'hEE
`define QTR_DIV 8'h0F
`define BYTES_PER_WR 2'h3
`define ENTRY_CNT 6'h1C
`define SEL_BASE 4'h0
`define SEL_SINGLE_MAX 4'h2
`endif

/* File: core/clkgen_pkg.sv */
package clkgen_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_LOAD = 7'h02,
    ST_START = 7'h04,
    ST_BIT = 7'h08,
    ST_ACK = 7'h10,
    ST_STOP = 7'h20,
    ST_DONE = 7'h40
  } ctl_state_t;
endpackage

/* File: core/clock_gen_i2c_config.sv */
`include "clkgen_cfg.svh"
// ==========================================================
// I2C loader for an external clock generator
module clock_gen_i2c_config
  import clkgen_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic config_trigger,
  input wire logic single_mode,
  input wire logic [11:0] channel_freq_select,
  input wire logic [3:0] memory_clk_freq_select,
  input wire logic sda_in,
  output logic scl_out_r,
  output logic sda_oe_r,
  output logic programming_complete_r,
  output logic ack_error_r
);
  ctl_state_t st_r, st_nxt;
  logic [1:0] trg_sync_r;
  logic trg_d_r;
  logic [1:0] sda_sync_r;
  logic [7:0] div_r;
  logic [1:0] ph_r;
  logic [5:0] idx_r;
  logic [1:0] byte_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic [15:0] entry_r;
  // ==========================================================
  // Input synchronisers and start edge
  wire logic trg_rise = trg_sync_r[1] & ~trg_d_r; // [RULE_02] [RULE_08]
  wire logic tick = (div_r == `QTR_DIV); // Quarter SCL period, 50 ns x 16 x 4 = 3.2 us [RULE_12]
  wire logic last_ph = tick && ph_r == 2'h3;
  wire logic entry_skip = entry_r[15:8] == 8'hFE;
  always_ff @(posedge clk)
  begin
    if (!resetn) // [RULE_01]
    begin
      trg_sync_r <= 2'h0;
      trg_d_r <= 1'b0;
      sda_sync_r <= 2'h3;
    end
    else if (ce)
    begin
      trg_sync_r <= {trg_sync_r[0], config_trigger};
      trg_d_r <= trg_sync_r[1];
      sda_sync_r <= {sda_sync_r[0], sda_in};
    end
  end
  reg_seq_table u_table
  (
    .clk(clk),
    .ce(ce),
    .idx(idx_r),
    .ch_sel(channel_freq_select),
    .mem_sel(memory_clk_freq_select),
    .single_mode(single_mode),
    .entry_r(entry_r)
  );
  // ==========================================================
  // Sequencer
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE, ST_DONE: if (trg_rise) st_nxt = ST_LOAD;
      ST_LOAD: if (last_ph) st_nxt = entry_skip ? ST_DONE : ST_START;
      ST_START: if (last_ph) st_nxt = ST_BIT;
      ST_BIT: if (last_ph && bit_r == 3'h0) st_nxt = ST_ACK;
      ST_ACK: if (last_ph) st_nxt = (byte_r == 2'h1 || ack_error_r) ? ST_STOP : ST_BIT;
      ST_STOP: if (last_ph) st_nxt = ST_LOAD;
      default: st_nxt = ST_IDLE;
    endcase
  end
  // Last cycle of the high SCL phases (end of phase 2) samples acknowledge [RULE_12]
  wire logic nack = st_r == ST_ACK && tick && ph_r == 2'h2 && sda_sync_r[1];
  always_ff @(posedge clk)
  begin
    if (!resetn) // [RULE_01]
    begin
      st_r <= ST_IDLE;
      div_r <= 8'h00;
      ph_r <= 2'h0;
      idx_r <= 6'h00;
      byte_r <= 2'h0;
      bit_r <= 3'h7;
      sh_r <= 8'h00;
      scl_out_r <= 1'b1;
      sda_oe_r <= 1'b0;
      programming_complete_r <= 1'b0;
      ack_error_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (tick)
        ph_r <= ph_r + 2'h1;
      if (trg_rise && (st_r == ST_IDLE || st_r == ST_DONE))
      begin
        idx_r <= `ENTRY_CNT - `ENTRY_CNT; // Restart table at entry zero
        programming_complete_r <= 1'b0; // [RULE_03]
        ack_error_r <= 1'b0;
        ph_r <= 2'h0;
        div_r <= 8'h00;
      end
      if (nack)
        ack_error_r <= 1'b1;
      case (st_r)
        ST_LOAD:
        begin
          scl_out_r <= 1'b1;
          sda_oe_r <= 1'b0;
          sh_r <= `DEV_ADDR_W; // [RULE_10]
          byte_r <= `BYTES_PER_WR;
          bit_r <= 3'h7;
          if (last_ph && entry_skip)
            programming_complete_r <= 1'b1; // [RULE_03]
        end
        ST_START:
        begin
          sda_oe_r <= ph_r >= 2'h1; // SDA falls while SCL high [RULE_12]
          scl_out_r <= ph_r < 2'h3;
        end
        ST_BIT:
        begin
          scl_out_r <= ph_r == 2'h1 || ph_r == 2'h2; // [RULE_04]
          sda_oe_r <= ~sh_r[7]; // Open drain: only ever pull low
          if (last_ph)
          begin
            sh_r <= {sh_r[6:0], 1'b0};
            bit_r <= bit_r - 3'h1;
          end
        end
        ST_ACK:
        begin
          scl_out_r <= ph_r == 2'h1 || ph_r == 2'h2;
          sda_oe_r <= 1'b0; // Release for the slave [RULE_04]
          if (last_ph)
          begin
            byte_r <= byte_r - 2'h1;
            bit_r <= 3'h7;
            sh_r <= (byte_r == 2'h3) ? entry_r[15:8] : entry_r[7:0];
          end
        end
        ST_STOP:
        begin
          scl_out_r <= ph_r != 2'h0;
          sda_oe_r <= ph_r < 2'h2; // SDA rises while SCL high [RULE_12]
          if (last_ph)
            idx_r <= idx_r + 6'h01; // Skip-sentinel ends the walk [RULE_09]
        end
        default:
        begin
          scl_out_r <= 1'b1;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* File: core/reg_seq_table.sv */
`include "clkgen_cfg.svh"
// ==========================================================
// Register sequencer table: index -> {addr, data}
module reg_seq_table
(
  input wire logic clk,
  input wire logic ce,
  input wire logic [5:0] idx,
  input wire logic [11:0] ch_sel,
  input wire logic [3:0] mem_sel,
  input wire logic single_mode,
  output logic [15:0] entry_r
);
  // Per-frequency divider byte; edit here to add frequencies [RULE_09]
  function automatic logic [7:0] ch_div(input logic [2:0] s);
    case (s)
      3'h1: ch_div = 8'h08; // 644.53125 MHz [RULE_06]
      3'h2: ch_div = 8'h10; // 322.26 MHz
      3'h3: ch_div = 8'h11; // 312.25 MHz
      3'h4: ch_div = 8'h15; // 250 MHz
      3'h5: ch_div = 8'h22; // 156.25 MHz
      3'h6: ch_div = 8'h2A; // 125 MHz
      3'h7: ch_div = 8'h35; // 100 MHz
      default: ch_div = 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] mem_div(input logic [3:0] s);
    case (s)
      4'h0: mem_div = 8'h13; // 275 MHz [RULE_07]
      4'h1: mem_div = 8'h15; // 250 MHz
      4'h2: mem_div = 8'h18; // 225 MHz
      default: mem_div = 8'h13;
    endcase
  endfunction
  // Four entries per channel; anything past channel 3 reads as the end sentinel
  wire logic [1:0] ch_n = idx[3:2];
  wire logic tbl_end = idx[5:4] != 2'h0;
  wire logic [3:0] ch_lsb = {1'b0, ch_n, 1'b0} + {2'h0, ch_n};
  wire logic [2:0] ch_s = ch_sel[ch_lsb +: 3];
  wire logic [7:0] div_b = single_mode ? mem_div(mem_sel) : ch_div(ch_s);
  // Powered-down channel: output driver disabled, divider entry still written with div_b 00 [RULE_05]
  wire logic [7:0] en_b = (single_mode || ch_s != 3'h0) ? 8'h01 : 8'h00;
  logic [15:0] entry;
  always_comb
  begin
    case (idx[1:0])
      2'h0: entry = {4'h1, 2'h0, ch_n, 2'h0, ch_n, 4'h0} | 16'h0000;
      2'h1: entry = {8'h2A, 6'h0, ch_n} + {8'h00, div_b};
      2'h2: entry = {4'h3, 2'h0, ch_n, en_b};
      2'h3: entry = {8'h1C, 8'h01};
      default: entry = {8'hFE, 8'h00};
    endcase
    if (tbl_end)
      entry = {8'hFE, 8'h00};
  end
  always_ff @(posedge clk)
  begin
    if (ce)
      entry_r <= entry;
  end
endmodule

/* File: sim/clkgen_cfg_props.sv */
// =====
// Port checker
module clkgen_cfg_props
  import clkgen_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic config_trigger,
  input wire logic scl_out_r,
  input wire logic sda_oe_r,
  input wire logic programming_complete_r,
  input wire logic ack_error_r
);
  logic [7:0] hold_r;
  logic scl_d_r;
  always_ff @(posedge clk)
  begin
    scl_d_r <= scl_out_r;
    // Saturated after reset so the edge that reset forces on SCL is not taken as fast
    hold_r <= !resetn ? 8'hFF : (scl_d_r != scl_out_r) ? 8'h00 : hold_r + {7'h00, hold_r != 8'hFF};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence trig_quiet;
    !config_trigger [*4];
  endsequence
  sequence run_busy;
    !programming_complete_r [*8];
  endsequence
  chk_reset_idle: assert property ($rose(resetn) |-> scl_out_r && !sda_oe_r && !programming_complete_r && !ack_error_r)
    else $error("outputs not idle after reset");
  chk_done_holds: assert property (trig_quiet ##0 programming_complete_r |=> programming_complete_r)
    else $error("done dropped without start");
  chk_start_edge: assert property ($fell(programming_complete_r) |-> $past(config_trigger, 2) || $past(config_trigger, 3))
    else $error("run began without trigger");
  chk_run_long: assert property ($fell(programming_complete_r) |-> run_busy)
    else $error("run ended too soon");
  chk_bus_idle: assert property (programming_complete_r |-> scl_out_r && !sda_oe_r)
    else $error("bus busy while done");
  chk_scl_rate: assert property ($changed(scl_out_r) |-> hold_r >= 8'h18)
    else $error("serial clock too fast");
  chk_ce_freeze: assert property (!ce |=> $stable(scl_out_r) && $stable(sda_oe_r) && $stable(programming_complete_r))
    else $error("state moved with ce low");
  chk_err_clear: assert property ($fell(ack_error_r) |-> !programming_complete_r)
    else $error("error cleared outside start");
endmodule

bind clock_gen_i2c_config clkgen_cfg_props u_props (.clk, .resetn, .ce, .config_trigger, .scl_out_r, .sda_oe_r,
  .programming_complete_r, .ack_error_r);

/* File: sim/clkgen_chip_model.sv */
// =====
// Generator chip, write side only; kept enabled and out of reset
module clkgen_chip_model
(
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  output logic sda_low,
  output logic [7:0] addr_byte,
  output int writes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  int bits = 0;
  int nbyte = 0;
  initial
  begin
    sda_low = 1'b0;
    writes = 0;
    addr_byte = 8'h00;
  end
  always @(negedge sda) if (scl) {bits, nbyte} = 0;
  always @(posedge sda) if (scl) writes++;
  always @(posedge scl)
  begin
    sh = {sh[6:0], sda};
    bits++;
  end
  // Ack held from one falling clock to the next, as a real slave does
  always @(negedge scl)
  begin
    if (bits == 8)
    begin
      sda_low = !nack;
      if (nbyte == 0) addr_byte = sh;
      nbyte++;
    end
    else if (bits == 9)
    begin
      sda_low = 1'b0;
      bits = 0;
    end
  end
endmodule

/* File: sim/testbench.sv */
// =====
// Loader bench
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, ce = 1, trig = 0, single_mode = 0, nack = 0;
  logic [11:0] ch_sel = 12'h688; // Channels 0..3 get codes 0..3
  logic [3:0] mem_sel = 4'h2;
  wire scl, sda_oe, done, err, sda_low;
  // Pulled-up line: high unless someone pulls it
  wire sda = !(sda_oe || sda_low);
  logic [7:0] addr_byte;
  int writes, num_errors = 0, cmp_count = 0;
  clock_gen_i2c_config dut (.clk, .resetn, .ce, .config_trigger(trig), .single_mode, .channel_freq_select(ch_sel),
    .memory_clk_freq_select(mem_sel), .sda_in(sda), .scl_out_r(scl), .sda_oe_r(sda_oe),
    .programming_complete_r(done), .ack_error_r(err));
  clkgen_chip_model chip (.scl, .sda, .nack, .sda_low, .addr_byte, .writes);
  initial forever #25 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic start_run();
    @(negedge clk) trig = 1;
    repeat (5) @(negedge clk);
    trig = 0;
  endtask
  task automatic wait_done();
    int n = 0;
    while (done !== 1'b1 && n < 40000)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic idle_chk();
    check(done, 0);
    check(scl, 1);
    check(sda_oe, 0);
    check(err, 0);
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    resetn = 1;
    @(negedge clk);
    idle_chk();
    start_run();
    check(done, 0);
    repeat (500) @(negedge clk);
    start_run(); // Second start mid-run must be ignored
    ce = 0;
    repeat (20) @(negedge clk);
    ce = 1;
    wait_done();
    check(done, 1);
    check(err, 0);
    check(addr_byte, 8'hEE);
    check(writes[7:0], 8'h10);
    ch_sel = 12'hFAC; // Codes 4..7
    nack = 1;
    start_run();
    check(done, 0);
    repeat (6000) @(negedge clk);
    check(err, 1);
    resetn = 0;
    @(negedge clk);
    resetn = 1;
    @(negedge clk);
    idle_chk();
    {nack, single_mode} = 2'b01;
    start_run();
    wait_done();
    check(done, 1);
    check(err, 0);
    results();
  end
  initial
  begin
    #5ms;
    num_errors++;
    results();
  end
endmodule
